// ### console_sequencer.sv
/*
 processor-side console mode sequencer: entry by request or breakpoint,
 command fetch, deposit of memory and registers, examine/deposit of i/o, exits.
 assumes the core reports instruction boundaries, fetches and faults,
 and performs a requested memory write, ic increment or register write.
*/
// Summary of operation
// [R1] console uses command, switch and display addresses
// [R2] request low: finish instruction, read command
// [R3] breakpoint reads config; console bit selects entry
// [R4] after each command, wait for new request
// [R5] request below interrupts, sampled at last cycle
// [R6] timers frozen throughout console mode
// [R7] console drops request, supplies command on read
// [R8] console bus cycles flag data cycle
// [R9] unknown command acts as no-op
// [R10] single step: resume, request at second fetch
// [R11] held request plus resume keeps console mode; code leaves it instead if an interrupt is pending
// [R12] fault in console mode blocks register writes
// [R13] memory store: switch word to ic location
// [R14] store-next increments ic before storing
// [R15] io read uses scratch pointer as address
// [R16] next variants increment pointer first
// [R17] command alone sets i/o direction
// [R18] console loads registers, then raises request
// [R19] disable: serve interrupt or poll both
// [R20] resume leaves console mode
// [R21] request synchronised before sampling
// [R22] command codes from shared table
`timescale 1ns/10ps
`default_nettype none
module console_sequencer
   import console_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // console link
   console_if.device link,
   // core status
   input wire logic last_cycle_i,
   input wire logic instr_done_i,
   input wire logic breakpoint_op_i,
   input wire logic irq_pending_i,
   input wire logic instr_fetch_i,
   input wire logic [ADDR_W-1:0] instruction_counter_i,
   // faults, active low
   input wire logic external_address_fault_n_i,
   input wire logic protection_fault_n_i,
   input wire logic parity_fault_n_i,
   // core control
   output logic core_hold_o,
   output logic timer_freeze_o,
   output logic bpt_nop_o,
   output logic ic_inc_o,
   output logic mem_req_o,
   output logic [ADDR_W-1:0] mem_addr_o,
   output logic [DATA_W-1:0] mem_wdata_o,
   input wire logic mem_ack_i,
   output logic reg_write_o,
   output logic [DATA_W-1:0] reg_wdata_o,
   output logic [DATA_W-1:0] scratch_io_pointer_o
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      seq_state_type st;
      logic [CMD_W-1:0] cmd;
      logic [DATA_W-1:0] ptr;
      logic [DATA_W-1:0] data;
      logic [ADDR_W-1:0] addr;
      logic we;
      logic fault;
      logic ic_inc;
      logic bpt_nop;
      logic reg_wr;
      logic [1:0] settle;
      logic resume;
   } seq_type;

   seq_type q, d;
   logic req_n;

   req_sync u_sync (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .async_n_i(link.console_request_n),
      .sync_n_o(req_n)
   ); // [R21]

   // command decode against the shared table
   function automatic logic is_known(input logic [CMD_W-1:0] c);
      unique case (c)
         CMD_STORE_MEM, CMD_STORE_NEXT_MEM, CMD_IO_READ,
         CMD_IO_READ_NEXT, CMD_IO_WRITE, CMD_IO_WRITE_NEXT,
         CMD_REG_WRITE, CMD_RESUME, CMD_DISABLE: is_known = 1'b1;
         default: is_known = 1'b0;
      endcase
   endfunction // [R22]

   function automatic logic is_next(input logic [CMD_W-1:0] c);
      is_next = (c == CMD_IO_READ_NEXT) || (c == CMD_IO_WRITE_NEXT);
   endfunction

   function automatic logic is_io_read(input logic [CMD_W-1:0] c);
      is_io_read = (c == CMD_IO_READ) || (c == CMD_IO_READ_NEXT);
   endfunction

   logic console_mode;
   logic any_fault;
   logic bus_ack;

   assign console_mode = !(q.st inside {ST_RUN, ST_PEND, ST_CFG});
   assign any_fault = !external_address_fault_n_i || !protection_fault_n_i
      || !parity_fault_n_i;
   assign bus_ack = link.io_ack;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      d = q;
      d.ic_inc = 1'b0;
      d.bpt_nop = 1'b0;
      d.reg_wr = 1'b0;
      // synced request lags the release by two edges
      if (q.settle != 2'h0)
         d.settle = q.settle - 2'h1;
      // fault latch held until console mode ends
      if (console_mode && any_fault)
         d.fault = 1'b1; // [R12]
      unique case (q.st)
         ST_RUN:
         begin
            d.fault = 1'b0;
            if (breakpoint_op_i)
            begin
               d.st = ST_CFG;
               d.addr = SYSCFG_ADDR;
               d.we = 1'b0;
            end
            else if (last_cycle_i && !req_n && !irq_pending_i)
               d.st = ST_PEND; // [R5]
         end
         ST_PEND:
            if (instr_done_i)
            begin
               d.st = ST_FETCH; // [R2]
               d.addr = CMD_ADDR;
               d.we = 1'b0;
            end
         ST_CFG:
            if (bus_ack)
            begin
               if (link.io_rdata[CFG_CONSOLE_BIT])
                  d.st = ST_IDLE; // [R3]
               else
               begin
                  d.st = ST_RUN;
                  d.bpt_nop = 1'b1;
               end
            end
         ST_FETCH:
            if (bus_ack)
            begin
               d.cmd = link.io_rdata[CMD_W-1:0];
               d.we = 1'b0;
               d.settle = 2'h2;
               d.st = ST_IDLE;
               if (!is_known(link.io_rdata[CMD_W-1:0]))
                  d.st = ST_IDLE; // [R9]
               else
                  unique case (link.io_rdata[CMD_W-1:0])
                     CMD_RESUME:
                     begin
                        // decided once the released request has settled
                        d.st = ST_IDLE;
                        d.resume = 1'b1;
                     end
                     CMD_DISABLE:
                        d.st = ST_INTERIM;
                     CMD_IO_READ, CMD_IO_READ_NEXT:
                     begin
                        if (is_next(link.io_rdata[CMD_W-1:0]))
                           d.ptr = q.ptr + 16'h0001; // [R16]
                        d.addr = is_next(link.io_rdata[CMD_W-1:0]) ?
                           q.ptr + 16'h0001 : q.ptr; // [R15]
                        d.st = ST_IO_RD;
                     end
                     default:
                     begin
                        if (link.io_rdata[CMD_W-1:0] == CMD_STORE_NEXT_MEM)
                           d.ic_inc = 1'b1; // [R14]
                        if (is_next(link.io_rdata[CMD_W-1:0]))
                           d.ptr = q.ptr + 16'h0001; // [R16]
                        d.addr = SWITCH_ADDR;
                        d.st = ST_DATA_RD;
                     end
                  endcase
            end
         ST_DATA_RD:
            if (bus_ack)
            begin
               d.data = link.io_rdata;
               unique case (q.cmd)
                  CMD_STORE_MEM, CMD_STORE_NEXT_MEM:
                     d.st = ST_MEM_WR; // [R13]
                  CMD_IO_WRITE, CMD_IO_WRITE_NEXT:
                  begin
                     // direction from the command, not address msb
                     d.addr = q.ptr;
                     d.we = 1'b1; // [R17]
                     d.st = ST_IO_WR;
                  end
                  default:
                  begin
                     if (!q.fault && !any_fault)
                     begin
                        d.reg_wr = 1'b1;
                        d.ptr = link.io_rdata; // [R12]
                     end
                     d.st = ST_IDLE;
                  end
               endcase
            end
         ST_IO_RD:
            if (bus_ack)
            begin
               d.data = link.io_rdata;
               d.addr = DISPLAY_ADDR; // [R1]
               d.we = 1'b1;
               d.st = ST_IO_WR;
            end
         ST_IO_WR:
            if (bus_ack)
            begin
               d.we = 1'b0;
               d.st = ST_IDLE;
            end
         ST_MEM_WR:
            if (mem_ack_i)
               d.st = ST_IDLE;
         ST_IDLE:
            // held request is caught before any instruction, except after resume with an interrupt pending
            if (q.settle == 2'h0 && !req_n
               && !(q.resume && irq_pending_i))
            begin
               d.st = ST_FETCH; // [R4] [R11]
               d.addr = CMD_ADDR;
               d.we = 1'b0;
               d.resume = 1'b0;
            end
            else if (q.settle == 2'h0 && q.resume)
            begin
               d.st = ST_RUN; // [R20]
               d.resume = 1'b0;
            end
         ST_INTERIM:
            if (irq_pending_i)
               d.st = ST_RUN; // [R19]
            else if (q.settle == 2'h0 && !req_n)
            begin
               d.st = ST_FETCH; // [R19]
               d.addr = CMD_ADDR;
               d.we = 1'b0;
            end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         q.st <= ST_RUN;
         q.cmd <= '0;
         q.ptr <= DATA_RESET;
         q.data <= DATA_RESET;
         q.addr <= '0;
         q.we <= 1'b0;
         q.fault <= 1'b0;
         q.ic_inc <= 1'b0;
         q.bpt_nop <= 1'b0;
         q.reg_wr <= 1'b0;
         q.settle <= 2'h0;
         q.resume <= 1'b0;
      end
      else
         q <= d;
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign link.io_req = q.st inside {ST_CFG, ST_FETCH, ST_DATA_RD,
      ST_IO_RD, ST_IO_WR};
   assign link.io_we = q.we;
   assign link.io_addr = q.addr;
   assign link.io_wdata = q.data;
   // console cycles are data cycles, breakpoint probe included
   assign link.data_cycle = link.io_req; // [R8]
   assign link.instr_fetch = instr_fetch_i;
   assign core_hold_o = q.st != ST_RUN && q.st != ST_PEND;
   assign timer_freeze_o = console_mode; // [R6]
   assign bpt_nop_o = q.bpt_nop;
   assign ic_inc_o = q.ic_inc;
   // for store-next, ic has already moved by the time this write is issued
   assign mem_req_o = q.st == ST_MEM_WR;
   assign mem_addr_o = instruction_counter_i;
   assign mem_wdata_o = q.data;
   assign reg_write_o = q.reg_wr;
   assign reg_wdata_o = q.ptr;
   assign scratch_io_pointer_o = q.ptr;
endmodule
`default_nettype wire

// ### console_pkg.sv
/*
 console sequencer shared constants: console i/o addresses, command
 codes, state encodings and bus widths.
 assumes a 16-bit i/o bus shared by the processor and the console logic.
*/
`default_nettype none
package console_pkg;

   // ---------------------------------------------------------------
   // bus shape
   // ---------------------------------------------------------------
   localparam int DATA_W = 16;
   localparam int ADDR_W = 16;
   localparam int CMD_W = 4;

   // ---------------------------------------------------------------
   // console i/o addresses
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] CMD_ADDR = 16'h8400;
   localparam logic [ADDR_W-1:0] SWITCH_ADDR = 16'h8401;
   localparam logic [ADDR_W-1:0] DISPLAY_ADDR = 16'h0400;
   localparam logic [ADDR_W-1:0] SYSCFG_ADDR = 16'h8410;
   // position of the console-present bit in the configuration word
   localparam int CFG_CONSOLE_BIT = 0;

   // ---------------------------------------------------------------
   // command table, shared by both ends
   // ---------------------------------------------------------------
   localparam logic [CMD_W-1:0] CMD_STORE_MEM = 4'h1;
   localparam logic [CMD_W-1:0] CMD_STORE_NEXT_MEM = 4'h2;
   localparam logic [CMD_W-1:0] CMD_IO_READ = 4'h3;
   localparam logic [CMD_W-1:0] CMD_IO_READ_NEXT = 4'h4;
   localparam logic [CMD_W-1:0] CMD_IO_WRITE = 4'h5;
   localparam logic [CMD_W-1:0] CMD_IO_WRITE_NEXT = 4'h6;
   localparam logic [CMD_W-1:0] CMD_REG_WRITE = 4'h7;
   localparam logic [CMD_W-1:0] CMD_RESUME = 4'h8;
   localparam logic [CMD_W-1:0] CMD_DISABLE = 4'h9;

   // ---------------------------------------------------------------
   // sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [9:0] {
      ST_RUN     = 10'h001,
      ST_PEND    = 10'h002,
      ST_CFG     = 10'h004,
      ST_FETCH   = 10'h008,
      ST_DATA_RD = 10'h010,
      ST_MEM_WR  = 10'h020,
      ST_IO_RD   = 10'h040,
      ST_IO_WR   = 10'h080,
      ST_IDLE    = 10'h100,
      ST_INTERIM = 10'h200
   } seq_state_type;

   // reset values
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
   localparam logic [1:0] SYNC_RESET = 2'h3;

endpackage
`default_nettype wire

// ### console_if.sv
/*
 interface joining the processor console sequencer and the console logic.
 assumes one clock shared by both ends; the request line is active low.
*/
`timescale 1ns/10ps
`default_nettype none
interface console_if;
   import console_pkg::*;

   logic console_request_n;
   logic io_req;
   logic io_we;
   logic [ADDR_W-1:0] io_addr;
   logic [DATA_W-1:0] io_wdata;
   logic [DATA_W-1:0] io_rdata;
   logic io_ack;
   logic data_cycle;
   logic instr_fetch;

   modport device (
      input console_request_n,
      input io_rdata,
      input io_ack,
      output io_req,
      output io_we,
      output io_addr,
      output io_wdata,
      output data_cycle,
      output instr_fetch
   );

   modport console (
      output console_request_n,
      output io_rdata,
      output io_ack,
      input io_req,
      input io_we,
      input io_addr,
      input io_wdata,
      input data_cycle,
      input instr_fetch
   );
endinterface
`default_nettype wire

// ### req_sync.sv
/*
 two-stage synchroniser for the console request.
 assumes an inactive-high level at reset.
*/
`timescale 1ns/10ps
`default_nettype none
module req_sync
   import console_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // level
   input wire logic async_n_i,
   output logic sync_n_o
);
   typedef struct packed {
      logic s1;
      logic s2;
   } sync_type;

   sync_type q, d;

   always_comb
   begin
      d.s1 = async_n_i;
      d.s2 = q.s1;
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         q <= SYNC_RESET;
      else
         q <= d;
   end

   assign sync_n_o = q.s2;
endmodule
`default_nettype wire

// ### console_logic.sv
/*
 external console control logic: holds command and switch registers,
 raises the request on a trigger or single-step fetch count, answers
 the processor's console i/o cycles and captures display writes.
 assumes the processor holds its i/o request until acknowledged.
*/
`timescale 1ns/10ps
`default_nettype none
module console_logic
   import console_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // console link
   console_if.console link,
   // operator side
   input wire logic load_i,
   input wire logic [CMD_W-1:0] cmd_i,
   input wire logic [DATA_W-1:0] switch_i,
   input wire logic trigger_i,
   input wire logic step_i,
   input wire logic console_present_i,
   output logic [DATA_W-1:0] display_o,
   output logic display_valid_o,
   output logic armed_o
);
   typedef struct packed {
      logic [CMD_W-1:0] cmd;
      logic [DATA_W-1:0] sw;
      logic [DATA_W-1:0] disp;
      logic disp_vld;
      logic armed;
      logic req_n;
      logic stepping;
      logic [1:0] fetches;
      logic ack;
      logic [DATA_W-1:0] rdata;
   } con_type;

   con_type q, d;

   always_comb
   begin
      d = q;
      d.ack = 1'b0;
      d.disp_vld = 1'b0;
      if (load_i)
      begin
         d.cmd = cmd_i;
         d.sw = switch_i;
         d.armed = 1'b1; // [R18]
      end
      if (q.armed && trigger_i)
         d.req_n = 1'b0; // [R18]
      // count fetches after a stepped resume
      if (q.stepping && link.instr_fetch)
      begin
         d.fetches = q.fetches + 2'h1;
         if (q.fetches == 2'h1)
         begin
            d.req_n = 1'b0; // [R10]
            d.stepping = 1'b0;
         end
      end
      if (link.io_req && !q.ack)
      begin
         d.ack = 1'b1;
         d.rdata = DATA_RESET;
         if (!link.io_we && link.io_addr == CMD_ADDR)
         begin
            d.rdata = {{(DATA_W-CMD_W){1'b0}}, q.cmd};
            d.req_n = 1'b1; // [R7]
            d.armed = 1'b0;
            d.stepping = step_i && q.cmd == CMD_RESUME; // [R10]
            d.fetches = 2'h0;
         end
         else if (!link.io_we && link.io_addr == SWITCH_ADDR)
            d.rdata = q.sw; // [R1]
         else if (!link.io_we && link.io_addr == SYSCFG_ADDR)
            d.rdata[CFG_CONSOLE_BIT] = console_present_i;
         else if (link.io_we && link.io_addr == DISPLAY_ADDR)
         begin
            d.disp = link.io_wdata; // [R1]
            d.disp_vld = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         q.cmd <= '0;
         q.sw <= DATA_RESET;
         q.disp <= DATA_RESET;
         q.disp_vld <= 1'b0;
         q.armed <= 1'b0;
         q.req_n <= 1'b1;
         q.stepping <= 1'b0;
         q.fetches <= 2'h0;
         q.ack <= 1'b0;
         q.rdata <= DATA_RESET;
      end
      else
         q <= d;
   end

   assign link.console_request_n = q.req_n;
   assign link.io_ack = q.ack;
   assign link.io_rdata = q.rdata;
   assign display_o = q.disp;
   assign display_valid_o = q.disp_vld;
   assign armed_o = q.armed;
endmodule
`default_nettype wire

// ### console_checker.sv
/*
 checker for the console link: handshake and console cycle properties.
 assumes instantiation beside the link interface, one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module console_checker
   import console_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // link signals
   input wire logic console_request_n,
   input wire logic io_req,
   input wire logic io_we,
   input wire logic [ADDR_W-1:0] io_addr,
   input wire logic [DATA_W-1:0] io_wdata,
   input wire logic io_ack,
   input wire logic data_cycle
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   // ----
   // handshake steps
   // ----
   sequence s_wait;
      io_req && !io_ack;
   endsequence
   sequence s_cmd_ack;
      io_req && !io_we && io_addr == CMD_ADDR && io_ack;
   endsequence
   AST_DATA_CYCLE: assert property (io_req |-> data_cycle)
      else $error("console cycle not flagged as data");
   AST_ACK_NEXT: assert property (s_wait |=> io_ack)
      else $error("console cycle not answered next cycle");
   AST_ACK_ONE: assert property (io_ack |=> !io_ack)
      else $error("answer longer than one cycle");
   AST_HOLD: assert property (s_wait |=> io_req && $stable(io_addr)
      && $stable(io_we) && $stable(io_wdata))
      else $error("cycle changed before answer");
   AST_RELEASE: assert property (s_cmd_ack |-> console_request_n)
      else $error("request kept low at command answer");
   AST_CMD_RD: assert property (io_req && io_addr == CMD_ADDR |-> !io_we)
      else $error("command address written");
   AST_SW_RD: assert property (io_req && io_addr == SWITCH_ADDR |-> !io_we)
      else $error("switch address written");
   AST_DISP_WR: assert property (io_req && io_addr == DISPLAY_ADDR |-> io_we)
      else $error("display address read");
   AST_FETCH_REQ: assert property ($rose(io_req) && io_addr == CMD_ADDR
      |-> !console_request_n)
      else $error("command fetch without request");
endmodule
`default_nettype wire

// ### testbench.sv
/*
 testbench: console sequencer and console logic joined by the link.
 assumes a core model here giving instruction timing and memory acks.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench
   import console_pkg::*;
;
   logic core_clk_i, rst_b_i, last_c, done_c, breakpoint_op, irq, ifet, mack;
   logic pfault_n, hold, frz, nop, icinc, mreq, regw, load, trig, step;
   logic present;
   logic [3:0] cmd;
   logic [15:0] ic, maddr, mwd, ptr, disp, sw, wr_a, wr_d, rd_a;
   logic [15:0] mem_a, mem_d;
   int error_cnt, n_tests, n_fetch, n_wr, n_reg, n_nop, n_if, ph, k;
   console_if link ();
   console_sequencer console_sequencer_i (.core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i), .link(link), .last_cycle_i(last_c),
      .instr_done_i(done_c), .breakpoint_op_i(breakpoint_op), .irq_pending_i(irq),
      .instr_fetch_i(ifet), .instruction_counter_i(ic),
      .external_address_fault_n_i(1'b1), .protection_fault_n_i(1'b1),
      .parity_fault_n_i(pfault_n), .core_hold_o(hold),
      .timer_freeze_o(frz), .bpt_nop_o(nop), .ic_inc_o(icinc),
      .mem_req_o(mreq), .mem_addr_o(maddr), .mem_wdata_o(mwd),
      .mem_ack_i(mack), .reg_write_o(regw), .reg_wdata_o(),
      .scratch_io_pointer_o(ptr));
   console_logic console_logic_i (.core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i), .link(link), .load_i(load), .cmd_i(cmd),
      .switch_i(sw), .trigger_i(trig), .step_i(step),
      .console_present_i(present), .display_o(disp),
      .display_valid_o(), .armed_o());
   console_checker console_checker_i (.core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i), .console_request_n(link.console_request_n),
      .io_req(link.io_req), .io_we(link.io_we), .io_addr(link.io_addr),
      .io_wdata(link.io_wdata), .io_ack(link.io_ack),
      .data_cycle(link.data_cycle));
   // ----
   // clock, core model, monitor
   // ----
   initial
   begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   // monitor first: it sees what stood through the last cycle
   always @(negedge core_clk_i)
   begin
      if (link.io_ack && link.io_addr == CMD_ADDR && !link.io_we)
         n_fetch++;
      else if (link.io_ack && link.io_we)
      begin
         wr_a = link.io_addr;
         wr_d = link.io_wdata;
         n_wr++;
      end
      else if (link.io_ack && link.io_addr != SWITCH_ADDR)
         rd_a = link.io_addr;
      if (mreq && !mack)
      begin
         mem_a = maddr;
         mem_d = mwd;
      end
      n_reg += int'(regw);
      n_nop += int'(nop);
      n_if += int'(link.instr_fetch);
      // core only stops at an instruction boundary
      if (ph == 0 && (hold || !rst_b_i))
      begin
         ifet = 1'b0;
         last_c = 1'b0;
         done_c = 1'b0;
      end
      else
      begin
         ifet = (ph == 0);
         last_c = (ph >= 4);
         done_c = (ph == 5);
         ph = (ph + 1) % 6;
      end
      if (icinc)
         ic = ic + 16'h0001;
      mack = mreq && !mack;
   end
   // ----
   // tasks
   // ----
   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task arm(input logic [3:0] c, input logic [15:0] d);
      @(negedge core_clk_i);
      load = 1'b1;
      cmd = c;
      sw = d;
      @(negedge core_clk_i);
      load = 1'b0;
      trig = 1'b1;
   endtask
   task wait_fetch(input int n);
      for (int i = 0; i < 300 && n_fetch < n; i++)
         @(negedge core_clk_i);
      trig = 1'b0;
      check(16'(n_fetch >= n), 16'h0001);
   endtask
   task run_cmd(input logic [3:0] c, input logic [15:0] d);
      arm(c, d);
      wait_fetch(n_fetch + 1);
      repeat (20) @(negedge core_clk_i);
   endtask
   task bpt_pulse;
      @(negedge core_clk_i);
      breakpoint_op = 1'b1;
      @(negedge core_clk_i);
      breakpoint_op = 1'b0;
      repeat (20) @(negedge core_clk_i);
   endtask
   // ----
   // tests
   // ----
   initial
   begin
      {last_c, done_c, breakpoint_op, irq, ifet, mack, load, trig, step} = '0;
      {pfault_n, present, rst_b_i} = 3'h6;
      {error_cnt, n_tests, n_fetch, n_wr, n_reg, n_nop, n_if, ph} = '0;
      {cmd, sw, ic} = '0;
      repeat (5) @(negedge core_clk_i);
      rst_b_i = 1'b1;
      check(16'(hold), 16'h0000);
      repeat (20) @(negedge core_clk_i);
      k = n_fetch;
      run_cmd(CMD_REG_WRITE, 16'h8401);
      check(16'(n_fetch - k), 16'h0001);
      check(16'(frz), 16'h0001);
      check(16'(hold), 16'h0001);
      check(ptr, 16'h8401);
      check(16'(n_reg), 16'h0001);
      $display("test entry done");
      ic = 16'h0100;
      run_cmd(CMD_STORE_MEM, 16'hBEEF);
      check(mem_a, 16'h0100);
      check(mem_d, 16'hBEEF);
      run_cmd(CMD_STORE_NEXT_MEM, 16'h1234);
      check(ic, 16'h0101);
      check(mem_a, 16'h0101);
      check(mem_d, 16'h1234);
      $display("test memory done");
      run_cmd(CMD_IO_READ, 16'hA5A5);
      check(disp, 16'hA5A5);
      check(wr_a, DISPLAY_ADDR);
      run_cmd(CMD_IO_READ_NEXT, 16'h0000);
      check(ptr, 16'h8402);
      check(rd_a, 16'h8402);
      run_cmd(CMD_IO_WRITE, 16'h00C3);
      check(wr_a, 16'h8402);
      check(wr_d, 16'h00C3);
      run_cmd(CMD_IO_WRITE_NEXT, 16'h003C);
      check(wr_a, 16'h8403);
      check(wr_d, 16'h003C);
      k = n_wr;
      run_cmd(4'hF, 16'h7777);
      check(16'(n_wr - k), 16'h0000);
      check(16'(hold), 16'h0001);
      $display("test io done");
      pfault_n = 1'b0;
      k = n_reg;
      run_cmd(CMD_REG_WRITE, 16'h0055);
      pfault_n = 1'b1;
      check(16'(n_reg - k), 16'h0000);
      check(ptr, 16'h8403);
      run_cmd(CMD_RESUME, 16'h0000);
      check(16'(hold), 16'h0000);
      check(16'(frz), 16'h0000);
      // request must wait while an interrupt is pending
      irq = 1'b1;
      k = n_fetch;
      arm(CMD_DISABLE, 16'h0000);
      repeat (30) @(negedge core_clk_i);
      check(16'(n_fetch - k), 16'h0000);
      irq = 1'b0;
      wait_fetch(k + 1);
      repeat (20) @(negedge core_clk_i);
      check(16'(hold), 16'h0001);
      irq = 1'b1;
      repeat (8) @(negedge core_clk_i);
      check(16'(hold), 16'h0000);
      irq = 1'b0;
      $display("test exit done");
      k = n_nop;
      present = 1'b0;
      bpt_pulse();
      check(16'(n_nop - k), 16'h0001);
      check(rd_a, SYSCFG_ADDR);
      present = 1'b1;
      bpt_pulse();
      check(16'(hold), 16'h0001);
      run_cmd(CMD_RESUME, 16'h0000);
      check(16'(hold), 16'h0000);
      step = 1'b1;
      arm(CMD_RESUME, 16'h0000);
      wait_fetch(n_fetch + 1);
      step = 1'b0;
      k = n_if;
      wait_fetch(n_fetch + 1);
      check(16'(n_if - k), 16'h0002);
      $display("test step done");
      repeat (20) @(negedge core_clk_i);
      report_and_stop();
   end
   initial
   begin
      #200000;
      error_cnt++;
      report_and_stop();
   end
endmodule
`default_nettype wire
